// [core/rsm_consts.vh]
// Notes on behaviour
// - buck fault latches on retry-burst flag, or enabled, soft-started and power not good.
// - ldo fault latches only when enabled, soft-started and power not good.
// - retry-burst flag latches when overcurrent counter terminates while power not good.
// - buck negative current limit flag latches whenever its threshold is reached.
// - zero-cross flag sets when detection active in pulse-skip mode and comparator trips.
// - latched status flags clear on register read; flags and read data zero after reset, live bits follow their inputs.
// - reserved status bits read zero: buck bit 3, ldo bits 6 to 4.
// - soft-start-done reads one only while enabled and ramp finished; live.
// - power-good bit shows live comparator output.
// - enabled bit reads one exactly while regulator enabled; live.
// - ldo current-limit bit reads one while in current limit; live.
// - top bit of a per-mode register enables buck one in that mode.
// - mode bit one selects forced pwm, zero automatic pulse skipping.
// - low six bits pick voltage code; reset code means 3.3 volts.
// - hibernate resets enable and mode low; active both high; low-power enable only.
// - retry-burst enable picks retry bursts or full shutdown with 100 ms restart.
// - with fault mask set, a fault flag does not pull interrupt low.
`ifndef RSM_CONSTS_VH
`define RSM_CONSTS_VH
// register offsets
`define RSM_ADDR_B4_STS 8'h08
`define RSM_ADDR_L1_STS 8'h09
`define RSM_ADDR_L2_STS 8'h0a
`define RSM_ADDR_B1_ACT 8'h10
`define RSM_ADDR_B1_LPM 8'h11
`define RSM_ADDR_B1_HIB 8'h12
// reset values of the per-mode registers and of the read data
`define RSM_RST_B1_ACT 8'hfb
`define RSM_RST_B1_LPM 8'hbb
`define RSM_RST_B1_HIB 8'h3b
`define RSM_RST_STS 8'h00
// field positions
`define RSM_BIT_EN 7
`define RSM_BIT_MODE 6
`define RSM_OUTPUT_VOLTAGE_CODE_HI 5
// power states
`define RSM_PS_ACTIVE 2'h0
`define RSM_PS_LOWPWR 2'h1
`define RSM_PS_HIBER 2'h2
// restart delay after shutdown: 100 ms at 25 MHz
`define RSM_RESTART_MS 100
`define RSM_CLK_KHZ 25000
`define RSM_RESTART_CYC (`RSM_RESTART_MS * `RSM_CLK_KHZ)
`endif

// [core/rsm_flag.v]
`include "rsm_consts.vh"
// =====================================
// sticky flag, cleared on read, set wins
module rsm_flag (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // event and clear
    input wire set_ev,
    input wire clr_rd,
    // flag
    output reg flag_q
);
    // a set arriving with the clear must survive the read
    always @(posedge clk_sys) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else if (set_ev) begin
            flag_q <= 1'b1;
        end else if (clr_rd) begin
            flag_q <= 1'b0;
        end
    end
endmodule // rsm_flag

// [core/rsm_regs.v]
`include "rsm_consts.vh"
// =====================================
// regulator status and buck one mode registers
module rsm_regs #(
    parameter [31:0] RESTART_CYC = `RSM_RESTART_CYC
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // register access port
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_q,
    // buck four analog status
    input wire b4_enabled,
    input wire b4_ss_done,
    input wire b4_pgood,
    input wire b4_oc_terminal,
    input wire b4_neg_current_limit_status,
    input wire b4_zc_trip,
    input wire b4_auto_pulse_skip,
    // ldo status
    input wire [1:0] ldo_enabled,
    input wire [1:0] ldo_ss_done,
    input wire [1:0] ldo_pgood,
    input wire [1:0] ldo_current_limit_status,
    // fault configuration
    input wire retry_burst_enable,
    input wire fault_mask,
    // power state
    input wire [1:0] power_state,
    // buck one controls
    output reg b1_enable_q,
    output reg forced_pwm_q,
    output reg [5:0] output_voltage_code_q,
    // fault response
    output reg all_shutdown_q,
    output reg retry_burst_q,
    output wire interrupt_out_n
);
    // =====================================
    // per-mode registers
    reg [7:0] act_q;
    reg [7:0] lpm_q;
    reg [7:0] hib_q;
    always @(posedge clk_sys) begin
        if (srst) begin
            act_q <= `RSM_RST_B1_ACT;
            lpm_q <= `RSM_RST_B1_LPM;
            hib_q <= `RSM_RST_B1_HIB;
        end else if (reg_wr) begin
            if (reg_addr == `RSM_ADDR_B1_ACT) begin
                act_q <= reg_wdata;
            end
            if (reg_addr == `RSM_ADDR_B1_LPM) begin
                lpm_q <= reg_wdata;
            end
            if (reg_addr == `RSM_ADDR_B1_HIB) begin
                hib_q <= reg_wdata;
            end
        end
    end

    // =====================================
    // select register for the current power state
    reg [7:0] sel_d;
    always @* begin
        case (power_state)
            `RSM_PS_ACTIVE: sel_d = act_q;
            `RSM_PS_LOWPWR: sel_d = lpm_q;
            `RSM_PS_HIBER: sel_d = hib_q;
            default: sel_d = act_q;
        endcase
    end

    // registered buck one controls
    always @(posedge clk_sys) begin
        if (srst) begin
            b1_enable_q <= 1'b0;
            forced_pwm_q <= 1'b0;
            output_voltage_code_q <= 6'h00;
        end else begin
            b1_enable_q <= sel_d[`RSM_BIT_EN];
            forced_pwm_q <= sel_d[`RSM_BIT_MODE];
            output_voltage_code_q <= sel_d[`RSM_OUTPUT_VOLTAGE_CODE_HI:0];
        end
    end

    // =====================================
    // event conditions
    wire rd_b4 = reg_rd && (reg_addr == `RSM_ADDR_B4_STS);
    wire rd_l1 = reg_rd && (reg_addr == `RSM_ADDR_L1_STS);
    wire rd_l2 = reg_rd && (reg_addr == `RSM_ADDR_L2_STS);
    wire b4_ss_live = b4_enabled & b4_ss_done;
    wire hiccup_ev = b4_oc_terminal & ~b4_pgood;
    wire hiccup_q;
    wire b4_flt_q;
    wire neg_q;
    wire zc_q;
    wire [1:0] l_flt_q;
    // fault also follows the latched retry-burst flag, but not across the read
    // that clears both, or the fault could never be cleared
    wire b4_flt_ev = hiccup_ev | (hiccup_q & ~rd_b4) | (b4_ss_live & ~b4_pgood);
    wire zc_ev = b4_auto_pulse_skip & b4_zc_trip;

    // =====================================
    // latched flags
    rsm_flag u_hic (
        .clk_sys(clk_sys), .srst(srst), .set_ev(hiccup_ev), .clr_rd(rd_b4), .flag_q(hiccup_q)
    );
    rsm_flag u_b4f (
        .clk_sys(clk_sys), .srst(srst), .set_ev(b4_flt_ev), .clr_rd(rd_b4), .flag_q(b4_flt_q)
    );
    rsm_flag u_neg (
        .clk_sys(clk_sys), .srst(srst), .set_ev(b4_neg_current_limit_status), .clr_rd(rd_b4), .flag_q(neg_q)
    );
    rsm_flag u_zc (
        .clk_sys(clk_sys), .srst(srst), .set_ev(zc_ev), .clr_rd(rd_b4), .flag_q(zc_q)
    );
    rsm_flag u_l1f (
        .clk_sys(clk_sys), .srst(srst),
        .set_ev(ldo_enabled[0] & ldo_ss_done[0] & ~ldo_pgood[0]),
        .clr_rd(rd_l1), .flag_q(l_flt_q[0])
    );
    rsm_flag u_l2f (
        .clk_sys(clk_sys), .srst(srst),
        .set_ev(ldo_enabled[1] & ldo_ss_done[1] & ~ldo_pgood[1]),
        .clr_rd(rd_l2), .flag_q(l_flt_q[1])
    );

    // =====================================
    // read data, registered; reserved bits are zero
    reg [7:0] rdata_d;
    always @* begin
        case (reg_addr)
            `RSM_ADDR_B4_STS: rdata_d = {b4_flt_q, hiccup_q, neg_q, zc_q, 1'b0,
                b4_ss_live, b4_pgood, b4_enabled};
            `RSM_ADDR_L1_STS: rdata_d = {l_flt_q[0], 3'h0, ldo_current_limit_status[0],
                ldo_enabled[0] & ldo_ss_done[0], ldo_pgood[0], ldo_enabled[0]};
            `RSM_ADDR_L2_STS: rdata_d = {l_flt_q[1], 3'h0, ldo_current_limit_status[1],
                ldo_enabled[1] & ldo_ss_done[1], ldo_pgood[1], ldo_enabled[1]};
            `RSM_ADDR_B1_ACT: rdata_d = act_q;
            `RSM_ADDR_B1_LPM: rdata_d = lpm_q;
            `RSM_ADDR_B1_HIB: rdata_d = hib_q;
            default: rdata_d = 8'h00;
        endcase
    end
    always @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata_q <= `RSM_RST_STS;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

    // =====================================
    // short-circuit response; shutdown holds the whole delay, then restarts
    reg [31:0] restart_cnt_q;
    always @(posedge clk_sys) begin
        if (srst) begin
            all_shutdown_q <= 1'b0;
            retry_burst_q <= 1'b0;
            restart_cnt_q <= 32'h0;
        end else begin
            retry_burst_q <= hiccup_ev & retry_burst_enable;
            if (all_shutdown_q) begin
                if (restart_cnt_q >= RESTART_CYC - 32'h1) begin
                    all_shutdown_q <= 1'b0;
                    restart_cnt_q <= 32'h0;
                end else begin
                    restart_cnt_q <= restart_cnt_q + 32'h1;
                end
            end else if (hiccup_ev && !retry_burst_enable) begin
                all_shutdown_q <= 1'b1;
            end
        end
    end

    // interrupt low while any fault is latched and not masked
    assign interrupt_out_n = ~((b4_flt_q | l_flt_q[0] | l_flt_q[1]) & ~fault_mask);
endmodule // rsm_regs

// [sim/rsm_regs_monitor.sv]
// =====
// status register and interrupt watcher
module rsm_mon (
    // clock, reset and register port
    input wire clk_sys, srst, reg_rd,
    input wire [7:0] reg_addr, reg_rdata_q,
    // live buck and ldo status
    input wire b4_enabled, b4_ss_done, b4_pgood, b4_neg_current_limit_status,
    input wire [1:0] ldo_enabled, ldo_ss_done, ldo_pgood, ldo_current_limit_status,
    // interrupt
    input wire fault_mask, interrupt_out_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // read data is the state one edge before it lands
    a_buck_rsvd_zero: assert property (reg_rd && reg_addr == 8'h08 |=> !reg_rdata_q[3])
        else $error("buck reserved bit set");
    a_ldo_rsvd_zero: assert property (reg_rd && (reg_addr == 8'h09 || reg_addr == 8'h0a)
        |=> reg_rdata_q[6:4] == 3'h0)
        else $error("ldo reserved bits set");
    a_live_power_good: assert property (reg_rd && reg_addr == 8'h08
        |=> reg_rdata_q[1] == $past(b4_pgood))
        else $error("power good bit wrong");
    a_live_enabled: assert property (reg_rd && reg_addr == 8'h08
        |=> reg_rdata_q[0] == $past(b4_enabled))
        else $error("enabled bit wrong");
    a_ssd_gated: assert property (reg_rd && reg_addr == 8'h08
        |=> reg_rdata_q[2] == ($past(b4_enabled) && $past(b4_ss_done)))
        else $error("soft start bit wrong");
    a_ldo_current_limit_status_live: assert property (reg_rd && reg_addr == 8'h0a
        |=> reg_rdata_q[3] == $past(ldo_current_limit_status[1]))
        else $error("ldo limit bit wrong");
    // a flag raised just before a read must show in it
    a_neg_current_limit_status_latch: assert property (b4_neg_current_limit_status ##1 reg_rd && reg_addr == 8'h08 |=> reg_rdata_q[5])
        else $error("negative limit flag lost");
    a_ldo_fault_set: assert property (ldo_enabled[0] && ldo_ss_done[0] && !ldo_pgood[0]
        ##1 reg_rd && reg_addr == 8'h09 |=> reg_rdata_q[7])
        else $error("ldo fault flag lost");
    a_mask_holds_irq: assert property (fault_mask |-> interrupt_out_n)
        else $error("masked fault drove interrupt");
endmodule // rsm_mon

bind rsm_regs rsm_mon i_rsm_mon (.clk_sys(clk_sys), .srst(srst), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata_q(reg_rdata_q), .b4_enabled(b4_enabled),
    .b4_ss_done(b4_ss_done), .b4_pgood(b4_pgood), .b4_neg_current_limit_status(b4_neg_current_limit_status),
    .ldo_enabled(ldo_enabled), .ldo_ss_done(ldo_ss_done), .ldo_pgood(ldo_pgood),
    .ldo_current_limit_status(ldo_current_limit_status), .fault_mask(fault_mask), .interrupt_out_n(interrupt_out_n));

// [sim/rsm_regs_test.sv]
module rsm_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, srst = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0, fault_mask = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ld = 8'h00, reg_rdata_q;
    logic [6:0] b4 = 7'h00;
    logic [1:0] power_state = 2'h0;
    logic b1_enable_q, forced_pwm_q, interrupt_out_n;
    logic rbe = 1'b1;
    logic retry_burst_q, all_shutdown_q;
    logic [5:0] output_voltage_code_q;
    int n_fail = 0, comparisons = 0;
    // =====
    // 25 mhz clock
    always #20 clk_sys = ~clk_sys;
    // short restart count keeps the shutdown path cheap
    rsm_regs #(.RESTART_CYC(20)) i_rsm_regs (.clk_sys(clk_sys), .srst(srst),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .b4_enabled(b4[0]), .b4_pgood(b4[1]), .b4_ss_done(b4[2]),
        .b4_oc_terminal(b4[3]), .b4_neg_current_limit_status(b4[4]), .b4_zc_trip(b4[5]),
        .b4_auto_pulse_skip(b4[6]), .ldo_enabled(ld[1:0]), .ldo_ss_done(ld[3:2]),
        .ldo_pgood(ld[5:4]), .ldo_current_limit_status(ld[7:6]), .retry_burst_enable(rbe),
        .fault_mask(fault_mask), .power_state(power_state), .b1_enable_q(b1_enable_q),
        .forced_pwm_q(forced_pwm_q), .output_voltage_code_q(output_voltage_code_q),
        .all_shutdown_q(all_shutdown_q), .retry_burst_q(retry_burst_q),
        .interrupt_out_n(interrupt_out_n));
    // =====
    // shared helpers
    task chk(input string n, input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // called just after an edge, returns just after one
    task rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys) reg_rd <= 1'b0;
        @(negedge clk_sys) chk($sformatf("reg %h", a), reg_rdata_q, e);
        @(posedge clk_sys);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys) reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    // buck one outputs, sampled mid-cycle
    task outs(input logic [7:0] e);
        @(negedge clk_sys) chk("buck1", {b1_enable_q, forced_pwm_q, output_voltage_code_q}, e);
        @(posedge clk_sys);
    endtask
    // =====
    // scenarios
    task t_reset;
        logic [7:0] ad [7] = '{8'h08, 8'h09, 8'h0a, 8'h10, 8'h11, 8'h12, 8'h30};
        logic [7:0] ex [7] = '{8'h00, 8'h00, 8'h00, 8'hfb, 8'hbb, 8'h3b, 8'h00};
        for (int i = 0; i < 7; i++) rd(ad[i], ex[i]);
        outs(8'hfb);
    endtask
    task t_buck;
        @(posedge clk_sys) b4 <= 7'h75;
        @(posedge clk_sys) b4 <= 7'h00;
        #1 chk("irq", {7'h00, interrupt_out_n}, 8'h00);
        rd(8'h08, 8'hb0);
        rd(8'h08, 8'h00);
        fault_mask <= 1'b1;
        b4 <= 7'h08;
        @(posedge clk_sys) b4 <= 7'h00;
        repeat (2) @(posedge clk_sys);
        rd(8'h08, 8'hc0);
        fault_mask <= 1'b0;
        b4 <= 7'h20;
        @(posedge clk_sys) b4 <= 7'h07;
        rd(8'h08, 8'h07);
    endtask
    task t_ldo;
        ld <= 8'haf;
        @(posedge clk_sys) ld <= 8'hbf;
        rd(8'h09, 8'h87);
        rd(8'h0a, 8'h0f);
        rd(8'h09, 8'h07);
    endtask
    // retry burst pulse, then full shutdown lasting the restart count
    task t_retry;
        int n;
        n = 0;
        rbe <= 1'b1;
        b4 <= 7'h08;
        @(posedge clk_sys) b4 <= 7'h00;
        @(negedge clk_sys) chk("burst", {6'h00, all_shutdown_q, retry_burst_q}, 8'h01);
        @(posedge clk_sys) rbe <= 1'b0;
        b4 <= 7'h08;
        @(posedge clk_sys) b4 <= 7'h00;
        repeat (100) begin
            @(negedge clk_sys);
            if (all_shutdown_q === 1'b1) n++;
        end
        chk("shutdown cycles", n[7:0], 8'h14);
        @(posedge clk_sys);
        rd(8'h08, 8'hc0);
        rd(8'h08, 8'h00);
    endtask
    task t_modes;
        b4 <= 7'h00;
        wr(8'h12, 8'hc5);
        wr(8'h08, 8'hff);
        wr(8'h30, 8'hff);
        power_state <= 2'h2;
        repeat (2) @(posedge clk_sys);
        outs(8'hc5);
        wr(8'h11, 8'h2a);
        power_state <= 2'h1;
        repeat (2) @(posedge clk_sys);
        outs(8'h2a);
        rd(8'h12, 8'hc5);
        rd(8'h08, 8'h00);
        rd(8'h30, 8'h00);
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // =====
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_buck();
        t_ldo();
        t_retry();
        t_modes();
        report_and_stop();
    end
endmodule // rsm_regs_test
